//--- shared/iap_flash_pkg.sv
// constants, register map and mode codes of the flash control block
package iap_flash_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_ADDR_LOW    = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH   = 8'h04;
    localparam logic [7:0] OFF_FIRST_LOW   = 8'h08;
    localparam logic [7:0] OFF_FIRST_HIGH  = 8'h0C;
    localparam logic [7:0] OFF_SECOND_LOW  = 8'h10;
    localparam logic [7:0] OFF_SECOND_HIGH = 8'h14;
    localparam logic [7:0] OFF_THIRD_LOW   = 8'h18;
    localparam logic [7:0] OFF_THIRD_HIGH  = 8'h1C;
    localparam logic [7:0] OFF_FOURTH_LOW  = 8'h20;
    localparam logic [7:0] OFF_FOURTH_HIGH = 8'h24;
    localparam logic [7:0] OFF_OP_CONTROL  = 8'h28;
    localparam logic [7:0] OFF_CHIP_RESET  = 8'h2C;
    localparam logic [7:0] OFF_BUF_CLEAR   = 8'h30;

    // flash_op_control field positions, then the buffer clear register bit
    localparam int BIT_ENABLED   = 7;
    localparam int BIT_MODE_HI   = 6;
    localparam int BIT_MODE_LO   = 4;
    localparam int BIT_TRIGGER   = 3;
    localparam int BIT_WRITE_INI = 2;
    localparam int BIT_READ_EN   = 1;
    localparam int BIT_READ_GO   = 0;
    localparam int BIT_BUF_CLEAR = 0;

    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    typedef enum logic [2:0] {
        MODE_WRITE  = 3'b000,
        MODE_ERASE  = 3'b001,
        MODE_READ   = 3'b011,
        MODE_UNLOCK = 3'b110
    } op_mode_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } op_state_t;

    // unlock pattern, data registers low then high
    localparam logic [7:0] KEY_SECOND_LOW  = 8'h00;
    localparam logic [7:0] KEY_THIRD_LOW   = 8'h0D;
    localparam logic [7:0] KEY_FOURTH_LOW  = 8'hC3;
    localparam logic [7:0] KEY_SECOND_HIGH = 8'h04;
    localparam logic [7:0] KEY_THIRD_HIGH  = 8'h09;
    localparam logic [7:0] KEY_FOURTH_HIGH = 8'h40;
    localparam logic [7:0] CHIP_RESET_KEY  = 8'h55;

    localparam logic [4:0] PAGE_LAST_WORD = 5'h1F;

    // unlock window, longest time so rounded down
    localparam int CLK_PERIOD_NS    = 10;
    localparam int UNLOCK_WINDOW_NS = 20000;
    localparam int UNLOCK_CYCLES    = UNLOCK_WINDOW_NS / CLK_PERIOD_NS;

    function automatic logic [7:0] regHit(input logic [7:0] a);
        return a;
    endfunction

endpackage

//--- hw/unlock_window_timer.sv
// timer that bounds the erase/write unlock window
`timescale 1ns/1ps
module unlock_window_timer #(
    parameter int unsigned CYCLES = 2000
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // control
    input  wire logic start,
    output logic      running,
    output logic      expire
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;

    logic [CW-1:0] count_reg;

    assign expire = running && (count_reg == ZERO);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            running   <= 1'b0;
            count_reg <= ZERO;
        end else if (start && !running) begin
            running   <= 1'b1;
            count_reg <= LOAD;
        end else if (expire) begin
            running <= 1'b0;
        end else if (running) begin
            count_reg <= count_reg - CW'(1);
        end
    end
endmodule

//--- hw/page_addr_counter.sv
// flash address pair with page-bounded auto increment
`timescale 1ns/1ps
module page_addr_counter #(
    parameter int AW = 13
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset,
    // software writes
    input  wire logic          wrLow,
    input  wire logic          wrHigh,
    input  wire logic [7:0]    wrData,
    // word loaded into buffer
    input  wire logic          incr,
    output logic      [AW-1:0] addr
);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            addr <= '0;
        end else if (wrLow) begin
            addr[7:0] <= wrData;
        end else if (wrHigh) begin
            addr[AW-1:8] <= wrData[AW-9:0];
        // stop on the last word so a page is never crossed
        end else if (incr && addr[4:0] != iap_flash_pkg::PAGE_LAST_WORD) begin
            addr <= addr + AW'(1);
        end
    end
endmodule

//--- hw/iap_flash_ctrl.sv
// flash programming control registers with apb access
`timescale 1ns/1ps
module iap_flash_ctrl #(
    parameter int unsigned UNLOCK_CYCLES = iap_flash_pkg::UNLOCK_CYCLES,
    parameter int          AW            = 13
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // flash array
    output logic               flashStart,
    output logic      [2:0]    flashMode,
    output logic      [AW-1:0] flashAddr,
    input  wire logic          flashDone,
    input  wire logic [15:0]   flashRdData,
    // write buffer
    output logic               bufLoad,
    output logic      [15:0]   bufData,
    output logic               bufClear,
    // system
    output logic               cpuStall,
    output logic               chipReset,
    output logic               eraseWriteEnabled
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] firstWordLow_reg;
    logic [7:0] firstWordHigh_reg;
    logic [7:0] secondWordLow_reg;
    logic [7:0] secondWordHigh_reg;
    logic [7:0] thirdWordLow_reg;
    logic [7:0] thirdWordHigh_reg;
    logic [7:0] fourthWordLow_reg;
    logic [7:0] fourthWordHigh_reg;
    logic [7:0] chipResetPattern_reg;
    logic [2:0] mode_reg;
    logic       readEnable_reg;
    logic       unlockTrigger_reg;
    logic       writeInitiate_reg;
    logic       readStart_reg;
    logic       bufClearStart_reg;
    iap_flash_pkg::op_state_t state_reg;
    logic [7:0] rdByte;
    logic       mapped;
    logic       access;
    logic       wrAcc;
    logic       timerRun;
    logic       timerExpire;
    logic       unlockHit;
    logic       startWrite;
    logic       startRead;
    logic       opDone;
    logic [2:0] newMode;

    ////////////////////////////////////////////////////////////////////
    // bus decode; one wait state so read data comes from a flop
    assign access  = psel && penable && !pready;
    assign wrAcc   = psel && penable && pready && pwrite;
    assign newMode = pwdata[iap_flash_pkg::BIT_MODE_HI:
                            iap_flash_pkg::BIT_MODE_LO];

    function automatic logic wrTo(input logic [7:0] off);
        return wrAcc && (paddr == off);
    endfunction

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            iap_flash_pkg::OFF_ADDR_LOW:    rdByte = flashAddr[7:0];
            iap_flash_pkg::OFF_ADDR_HIGH:
                rdByte = 8'(flashAddr[AW-1:8]);
            iap_flash_pkg::OFF_FIRST_LOW:   rdByte = firstWordLow_reg;
            iap_flash_pkg::OFF_FIRST_HIGH:  rdByte = firstWordHigh_reg;
            iap_flash_pkg::OFF_SECOND_LOW:  rdByte = secondWordLow_reg;
            iap_flash_pkg::OFF_SECOND_HIGH: rdByte = secondWordHigh_reg;
            iap_flash_pkg::OFF_THIRD_LOW:   rdByte = thirdWordLow_reg;
            iap_flash_pkg::OFF_THIRD_HIGH:  rdByte = thirdWordHigh_reg;
            iap_flash_pkg::OFF_FOURTH_LOW:  rdByte = fourthWordLow_reg;
            iap_flash_pkg::OFF_FOURTH_HIGH: rdByte = fourthWordHigh_reg;
            iap_flash_pkg::OFF_OP_CONTROL:
                rdByte = {eraseWriteEnabled, mode_reg, unlockTrigger_reg,
                          writeInitiate_reg, readEnable_reg, readStart_reg};
            iap_flash_pkg::OFF_CHIP_RESET:  rdByte = chipResetPattern_reg;
            iap_flash_pkg::OFF_BUF_CLEAR:   rdByte = {7'h00,
                                                      bufClearStart_reg};
            default: begin
                rdByte = iap_flash_pkg::BYTE_RESET;
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= iap_flash_pkg::WORD_ZERO;
        end else begin
            pready  <= access;
            pslverr <= access && !mapped;
            if (access && !pwrite) begin
                prdata <= {24'h00_0000, rdByte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data pairs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            secondWordLow_reg  <= iap_flash_pkg::BYTE_RESET;
            secondWordHigh_reg <= iap_flash_pkg::BYTE_RESET;
            thirdWordLow_reg   <= iap_flash_pkg::BYTE_RESET;
            thirdWordHigh_reg  <= iap_flash_pkg::BYTE_RESET;
            fourthWordLow_reg  <= iap_flash_pkg::BYTE_RESET;
            fourthWordHigh_reg <= iap_flash_pkg::BYTE_RESET;
            chipResetPattern_reg <= iap_flash_pkg::BYTE_RESET;
        end else begin
            if (wrTo(iap_flash_pkg::OFF_SECOND_LOW))
                secondWordLow_reg <= pwdata[7:0];
            if (wrTo(iap_flash_pkg::OFF_SECOND_HIGH))
                secondWordHigh_reg <= pwdata[7:0];
            if (wrTo(iap_flash_pkg::OFF_THIRD_LOW))
                thirdWordLow_reg <= pwdata[7:0];
            if (wrTo(iap_flash_pkg::OFF_THIRD_HIGH))
                thirdWordHigh_reg <= pwdata[7:0];
            if (wrTo(iap_flash_pkg::OFF_FOURTH_LOW))
                fourthWordLow_reg <= pwdata[7:0];
            if (wrTo(iap_flash_pkg::OFF_FOURTH_HIGH))
                fourthWordHigh_reg <= pwdata[7:0];
            if (wrTo(iap_flash_pkg::OFF_CHIP_RESET))
                chipResetPattern_reg <= pwdata[7:0];
        end
    end

    // first word pair; a finished read lands here
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            firstWordLow_reg  <= iap_flash_pkg::BYTE_RESET;
            firstWordHigh_reg <= iap_flash_pkg::BYTE_RESET;
        end else if (opDone && readStart_reg) begin
            {firstWordHigh_reg, firstWordLow_reg} <= flashRdData;
        end else begin
            if (wrTo(iap_flash_pkg::OFF_FIRST_LOW))
                firstWordLow_reg <= pwdata[7:0];
            if (wrTo(iap_flash_pkg::OFF_FIRST_HIGH))
                firstWordHigh_reg <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // unlock procedure
    unlock_window_timer #(
        .CYCLES (UNLOCK_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .reset   (reset),
        .start   (unlockTrigger_reg),
        .running (timerRun),
        .expire  (timerExpire)
    );

    // pattern checked only while the window is open
    assign unlockHit = timerRun && !eraseWriteEnabled
        && secondWordLow_reg  == iap_flash_pkg::KEY_SECOND_LOW
        && thirdWordLow_reg   == iap_flash_pkg::KEY_THIRD_LOW
        && fourthWordLow_reg  == iap_flash_pkg::KEY_FOURTH_LOW
        && secondWordHigh_reg == iap_flash_pkg::KEY_SECOND_HIGH
        && thirdWordHigh_reg  == iap_flash_pkg::KEY_THIRD_HIGH
        && fourthWordHigh_reg == iap_flash_pkg::KEY_FOURTH_HIGH;

    // hardware set wins over a software clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            eraseWriteEnabled <= 1'b0;
        end else if (unlockHit) begin
            eraseWriteEnabled <= 1'b1;
        end else if (wrTo(iap_flash_pkg::OFF_OP_CONTROL)
                     && !pwdata[iap_flash_pkg::BIT_ENABLED]) begin
            eraseWriteEnabled <= 1'b0;
        end
    end

    // trigger only in unlock mode, dropped at timeout
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            unlockTrigger_reg <= 1'b0;
        end else if (timerExpire) begin
            unlockTrigger_reg <= 1'b0;
        end else if (wrTo(iap_flash_pkg::OFF_OP_CONTROL)
                     && pwdata[iap_flash_pkg::BIT_TRIGGER]
                     && newMode == iap_flash_pkg::MODE_UNLOCK) begin
            unlockTrigger_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // operation start; a refused start leaves its bit low
    assign opDone = (state_reg == iap_flash_pkg::ST_BUSY) && flashDone;
    // only write and erase codes start a write process
    assign startWrite = wrTo(iap_flash_pkg::OFF_OP_CONTROL)
        && pwdata[iap_flash_pkg::BIT_WRITE_INI] && eraseWriteEnabled
        && state_reg == iap_flash_pkg::ST_IDLE
        && (newMode == iap_flash_pkg::MODE_WRITE
            || newMode == iap_flash_pkg::MODE_ERASE);
    // read gated by the stored read enable
    assign startRead = wrTo(iap_flash_pkg::OFF_OP_CONTROL)
        && pwdata[iap_flash_pkg::BIT_READ_GO] && readEnable_reg
        && state_reg == iap_flash_pkg::ST_IDLE
        && newMode == iap_flash_pkg::MODE_READ;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_reg       <= iap_flash_pkg::MODE_WRITE;
            readEnable_reg <= 1'b0;
        end else if (wrTo(iap_flash_pkg::OFF_OP_CONTROL)) begin
            mode_reg       <= newMode;
            readEnable_reg <= pwdata[iap_flash_pkg::BIT_READ_EN];
        end
    end

    // start bits fall with the array done
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg         <= iap_flash_pkg::ST_IDLE;
            writeInitiate_reg <= 1'b0;
            readStart_reg     <= 1'b0;
            cpuStall          <= 1'b0;
        end else begin
            case (state_reg)
                iap_flash_pkg::ST_IDLE: begin
                    if (startWrite || startRead) begin
                        state_reg         <= iap_flash_pkg::ST_BUSY;
                        writeInitiate_reg <= startWrite;
                        readStart_reg     <= startRead;
                        cpuStall          <= 1'b1;
                    end
                end
                iap_flash_pkg::ST_BUSY: begin
                    if (flashDone) begin
                        state_reg         <= iap_flash_pkg::ST_IDLE;
                        writeInitiate_reg <= 1'b0;
                        readStart_reg     <= 1'b0;
                        cpuStall          <= 1'b0;
                    end
                end
                default: state_reg <= iap_flash_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flashStart <= 1'b0;
            flashMode  <= iap_flash_pkg::MODE_WRITE;
        end else begin
            flashStart <= startWrite || startRead;
            if (startWrite || startRead)
                flashMode <= newMode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer clear takes one cycle at the buffer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bufClearStart_reg <= 1'b0;
            bufClear          <= 1'b0;
        end else begin
            bufClearStart_reg <= !bufClearStart_reg
                && wrTo(iap_flash_pkg::OFF_BUF_CLEAR)
                && pwdata[iap_flash_pkg::BIT_BUF_CLEAR];
            // buffer wiped after a write; an erase leaves it intact
            bufClear <= bufClearStart_reg || (opDone && writeInitiate_reg
                && flashMode == iap_flash_pkg::MODE_WRITE);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset)
            chipReset <= 1'b0;
        else
            chipReset <= wrTo(iap_flash_pkg::OFF_CHIP_RESET)
                && pwdata[7:0] == iap_flash_pkg::CHIP_RESET_KEY;
    end

    // first high write loads the buffer word while erase/write is enabled
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bufLoad <= 1'b0;
            bufData <= 16'h0000;
        end else begin
            bufLoad <= wrTo(iap_flash_pkg::OFF_FIRST_HIGH)
                && eraseWriteEnabled;
            if (wrTo(iap_flash_pkg::OFF_FIRST_HIGH))
                bufData <= {pwdata[7:0], firstWordLow_reg};
        end
    end

    // bounded increment lives in the counter
    page_addr_counter #(
        .AW (AW)
    ) u_addr (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wrLow   (wrTo(iap_flash_pkg::OFF_ADDR_LOW)),
        .wrHigh  (wrTo(iap_flash_pkg::OFF_ADDR_HIGH)),
        .wrData  (pwdata[7:0]),
        .incr    (bufLoad),
        .addr    (flashAddr)
    );

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_ENABLE_HW_ONLY: assert property (
        $rose(eraseWriteEnabled) |-> $past(timerRun))
        else $error("enabled flag rose outside unlock window");
    AST_ENABLE_CLEAR: assert property (
        wrTo(iap_flash_pkg::OFF_OP_CONTROL)
        && !pwdata[iap_flash_pkg::BIT_ENABLED] && !unlockHit
        |=> !eraseWriteEnabled)
        else $error("zero write did not disable erase/write");
    AST_MODE_LEGAL: assert property (
        flashStart |-> flashMode inside {iap_flash_pkg::MODE_WRITE,
            iap_flash_pkg::MODE_ERASE, iap_flash_pkg::MODE_READ})
        else $error("operation started with reserved mode");
    AST_TRIGGER_TIMEOUT: assert property (
        timerExpire |=> !unlockTrigger_reg && !timerRun)
        else $error("trigger not cleared at timeout");
    AST_STALL_MATCH: assert property (
        cpuStall == (writeInitiate_reg || readStart_reg))
        else $error("stall differs from running operation");
    AST_READ_GATED: assert property (
        flashStart && flashMode == iap_flash_pkg::MODE_READ
        |-> $past(readEnable_reg))
        else $error("read started without read enable");
    AST_DONE_RELEASE: assert property (
        opDone |=> !cpuStall && !writeInitiate_reg && !readStart_reg)
        else $error("done did not end operation");
    AST_CHIP_RESET: assert property (
        wrTo(iap_flash_pkg::OFF_CHIP_RESET)
        && pwdata[7:0] == iap_flash_pkg::CHIP_RESET_KEY
        |=> chipReset ##1 !chipReset)
        else $error("chip reset pulse wrong");
    AST_CLEAR_SELF: assert property (
        bufClearStart_reg |=> bufClear && !bufClearStart_reg)
        else $error("buffer clear did not complete");
    AST_CLEAR_UPPER_ZERO: assert property (
        pready && !pwrite && paddr == iap_flash_pkg::OFF_BUF_CLEAR
        |-> prdata[7:1] == 7'h00)
        else $error("buffer clear upper bits not zero");
    AST_LOAD_INC: assert property (
        bufLoad && flashAddr[4:0] != iap_flash_pkg::PAGE_LAST_WORD
        |=> flashAddr == $past(flashAddr) + AW'(1))
        else $error("address not incremented after load");
    AST_PAGE_STOP: assert property (
        bufLoad && flashAddr[4:0] == iap_flash_pkg::PAGE_LAST_WORD
        |=> $stable(flashAddr))
        else $error("address crossed page boundary");
    AST_WRITE_CLEARS: assert property (
        opDone && writeInitiate_reg
        && flashMode == iap_flash_pkg::MODE_WRITE |=> bufClear)
        else $error("buffer not cleared after write");

    COV_UNLOCK: cover property ($rose(eraseWriteEnabled));
    COV_WRITE: cover property (opDone && writeInitiate_reg);
    COV_READ: cover property (opDone && readStart_reg);
    COV_RESET: cover property (chipReset);
endmodule

//--- verif/flash_array_model.sv
// behavioural flash array that answers each start after a set delay
`timescale 1ns/1ps
module flash_array_model #(
    parameter logic [15:0] WORD = 16'hA5C3
) (
    // clock
    input  wire logic        clk_sys,
    // start from the block, slow select from the bench
    input  wire logic        flashStart,
    input  wire logic        slow,
    // answer
    output logic             flashDone,
    output logic      [15:0] flashRdData
);
    int cnt = 0;
    initial flashDone = 1'b0;
    initial flashRdData = 16'h0000;
    ////////////////////////////////////////////////////////////////////
    // done pulse
    // read word only valid with done, otherwise toggles so stale data fails
    always @(posedge clk_sys) begin
        flashDone <= (cnt == 1);
        flashRdData <= (cnt == 1) ? WORD : ~flashRdData;
        if (flashStart === 1'b1)
            cnt <= slow ? 40 : 2;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

//--- verif/iap_flash_control_registers_bench.sv
// self-checking bench of the flash control registers
`timescale 1ns/1ps
module iap_flash_control_registers_bench;
    localparam logic [7:0]  OPC  = iap_flash_pkg::OFF_OP_CONTROL;
    localparam logic [15:0] WORD = 16'hA5C3;
    logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
    logic        flashStart, flashDone, bufLoad, bufClear, cpuStall;
    logic        chipReset, eraseWriteEnabled, slow, err;
    logic [7:0]  paddr, r;
    logic [31:0] pwdata, prdata;
    logic [2:0]  flashMode, expMode;
    logic [12:0] flashAddr;
    logic [15:0] flashRdData, bufData, rnd;
    int          n_fail, samples_checked, nLoad, nClr, nStart, nChip, i;
    int          ldq[$];
    int          expReg[13];
    logic [7:0]  key[6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
    logic [2:0]  res[4] = '{3'b010, 3'b100, 3'b101, 3'b111};

    iap_flash_ctrl #(.UNLOCK_CYCLES(60), .AW(13)) uut (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flashStart(flashStart),
        .flashMode(flashMode), .flashAddr(flashAddr),
        .flashDone(flashDone), .flashRdData(flashRdData),
        .bufLoad(bufLoad), .bufData(bufData), .bufClear(bufClear),
        .cpuStall(cpuStall), .chipReset(chipReset),
        .eraseWriteEnabled(eraseWriteEnabled));
    flash_array_model #(.WORD(WORD)) array (
        .clk_sys(clk_sys), .flashStart(flashStart), .slow(slow),
        .flashDone(flashDone), .flashRdData(flashRdData));
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk_sys);
        if (k == 20) begin
            n_fail++;
            end_of_test();
        end
        r = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, m, e);
        apb(1'b0, a, 8'h00);
        chk(r & m, e);
    endtask
    task automatic waitIdle(input int starts);
        int k;
        @(posedge clk_sys);
        #1 chk(cpuStall, 1'b1);
        for (k = 0; k < 100 && cpuStall !== 1'b0; k++) @(posedge clk_sys);
        chk(cpuStall, 1'b0);
        if (k == 100) end_of_test();
        chk(nStart, starts);
    endtask
    // pulses are sampled before the edge updates land
    always @(posedge clk_sys) begin
        if (bufLoad === 1'b1) begin
            nLoad++;
            chk(bufData, ldq.pop_front());
        end
        if (flashStart === 1'b1) begin
            nStart++;
            chk(flashMode, expMode);
        end
        nClr += int'(bufClear === 1'b1);
        nChip += int'(chipReset === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, slow, err} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        expMode = 3'b000;
        rnd = 16'h4D3E;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        for (i = 2; i < 13; i++) rd(8'(i * 4), 8'hFF, 8'h00);
        for (i = 4; i < 10; i++) begin
            rnd = lfsr(rnd);
            expReg[i] = int'(rnd[7:0]);
            apb(1'b1, 8'(i * 4), rnd[7:0]);
        end
        for (i = 4; i < 10; i++) rd(8'(i * 4), 8'hFF, 8'(expReg[i]));
        apb(1'b0, 8'h3C, 8'h00);
        chk({err, r}, 9'h100);
        $display("test registers done");
        apb(1'b1, OPC, 8'h80);
        apb(1'b1, OPC, 8'h14);
        repeat (4) @(posedge clk_sys);
        chk(eraseWriteEnabled, 1'b0);
        chk(nStart, 0);
        apb(1'b1, OPC, 8'h68);
        rd(OPC, 8'h08, 8'h08);
        for (i = 0; i < 6; i++) apb(1'b1, 8'(16 + 4 * i), key[i]);
        rd(OPC, 8'h80, 8'h80);
        repeat (70) @(posedge clk_sys);
        rd(OPC, 8'h08, 8'h00);
        $display("test unlock done");
        apb(1'b1, 8'h00, 8'h1E);
        apb(1'b1, 8'h08, 8'h11);
        for (i = 0; i < 3; i++) begin
            ldq.push_back({8'(8'h22 + i), 8'h11});
            apb(1'b1, 8'h0C, 8'(8'h22 + i));
        end
        rd(8'h00, 8'hFF, 8'h1F);
        chk(nLoad, 3);
        $display("test buffer done");
        // slow array answer after 40 cycles, one bit per write
        slow <= 1'b1;
        expMode = 3'b001;
        apb(1'b1, OPC, 8'h90);
        apb(1'b1, OPC, 8'h94);
        waitIdle(1);
        rd(OPC, 8'h04, 8'h00);
        slow <= 1'b0;
        expMode = 3'b000;
        apb(1'b1, OPC, 8'h80);
        apb(1'b1, OPC, 8'h84);
        waitIdle(2);
        repeat (2) @(posedge clk_sys);
        chk(nClr, 1);
        for (i = 0; i < 4; i++) apb(1'b1, OPC, {1'b1, res[i], 4'h4});
        repeat (4) @(posedge clk_sys);
        chk(nStart, 2);
        $display("test erase write done");
        apb(1'b1, OPC, 8'h30);
        apb(1'b1, OPC, 8'h31);
        repeat (4) @(posedge clk_sys);
        chk(nStart, 2);
        chk(eraseWriteEnabled, 1'b0);
        expMode = 3'b011;
        apb(1'b1, OPC, 8'h32);
        apb(1'b1, OPC, 8'h33);
        waitIdle(3);
        rd(8'h08, 8'hFF, WORD[7:0]);
        rd(8'h0C, 8'hFF, WORD[15:8]);
        rd(OPC, 8'h01, 8'h00);
        $display("test read done");
        apb(1'b1, 8'h30, 8'hFF);
        rd(8'h30, 8'hFF, 8'h00);
        chk(nClr, 2);
        apb(1'b1, 8'h2C, 8'h54);
        apb(1'b1, 8'h2C, 8'h55);
        rd(8'h2C, 8'hFF, 8'h55);
        chk(nChip, 1);
        $display("test clear and chip reset done");
        end_of_test();
    end
endmodule
